/* File: src/abx_consts.vh */
// Constants for the arithmetic, bit and branch execution block
`ifndef ABX_CONSTS_VH
`define ABX_CONSTS_VH
`define ABX_OP_ADD 3'h0
`define ABX_OP_ADDC 3'h1
`define ABX_OP_ASR 3'h2
`define ABX_OP_BCLR 3'h3
`define ABX_OP_BTSZ 3'h4
`define ABX_OP_BRA 3'h5
`define ABX_DEST_ACC 1'h0
`define ABX_DEST_FILE 1'h1
`define ABX_ADDR_W 7
`define ABX_PC_W 15
`define ABX_OFS_W 9
`define ABX_BIT_C 0
`define ABX_BIT_DC 1
`define ABX_BIT_Z 2
`define ABX_ACC_RST 8'h00
`define ABX_FLAGS_RST 3'h0
`define ABX_PC_RST 15'h0000
`define ABX_ST_EXEC 1'h0
`define ABX_ST_FLUSH 1'h1
`endif

/* File: src/abx_alu.v */
// Combinational adder and shifter with flag generation
`timescale 1ns/10ps
module abx_alu (
	a,
	b,
	cin,
	shift,
	res,
	c_out,
	dc_out,
	z_out
);
	input wire [7:0] a;
	input wire [7:0] b;
	input wire cin;
	input wire shift;
	output reg [7:0] res;
	output reg c_out;
	output reg dc_out;
	output reg z_out;
	reg [4:0] lo;
	reg [4:0] hi;
	always @* begin
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		if (shift) begin
			res = {b[7], b[7:1]};
			c_out = b[0];
			dc_out = 1'b0;
		end else begin
			res = {hi[3:0], lo[3:0]};
			c_out = hi[4];
			dc_out = lo[4];
		end
		z_out = (res == 8'h00);
	end
endmodule // abx_alu

/* File: src/abx_exec.v */
// Execution unit for add, add with carry, arithmetic shift, bit clear, bit test skip and relative jump
//
// Contract
// - Add accumulator and file, update C, DC, Z
// - Destination bit picks accumulator or file
// - Add with carry includes current carry flag
// - Shift right, old bit 0 into carry
// - Shift keeps sign bit unchanged
// - Bit clear zeroes one bit, flags untouched
// - Skip next instruction when tested bit zero
// - Jump to incremented PC plus signed offset
// - Jump takes two cycles; no flag changes
`timescale 1ns/10ps
`include "abx_consts.vh"
module abx_exec #(
	parameter ADDR_W = `ABX_ADDR_W,
	parameter PC_W = `ABX_PC_W
) (
	clk,
	rst_n,
	instr_valid,
	op,
	file_addr,
	dest_sel,
	bit_sel,
	jump_ofs,
	pc_in,
	file_rdata,
	acc,
	carry_flag,
	half_carry_flag,
	zero_flag,
	file_we,
	file_waddr,
	file_wdata,
	pc_load,
	pc_target,
	discard_next,
	busy
);
	input wire clk;
	input wire rst_n;
	input wire instr_valid;
	input wire [2:0] op;
	input wire [ADDR_W-1:0] file_addr;
	input wire dest_sel;
	input wire [2:0] bit_sel;
	input wire [`ABX_OFS_W-1:0] jump_ofs;
	input wire [PC_W-1:0] pc_in;
	input wire [7:0] file_rdata;
	output wire [7:0] acc;
	output wire carry_flag;
	output wire half_carry_flag;
	output wire zero_flag;
	output wire file_we;
	output wire [ADDR_W-1:0] file_waddr;
	output wire [7:0] file_wdata;
	output wire pc_load;
	output wire [PC_W-1:0] pc_target;
	output wire discard_next;
	output wire busy;

	////////////////////////////////////////////////////////////////////////////////
	reg [7:0] acc_r;
	reg [7:0] acc_nxt;
	reg [2:0] flags_r;
	reg [2:0] flags_nxt;
	reg file_we_r;
	reg file_we_nxt;
	reg [ADDR_W-1:0] file_waddr_r;
	reg [7:0] file_wdata_r;
	reg [7:0] file_wdata_nxt;
	reg pc_load_r;
	reg pc_load_nxt;
	reg [PC_W-1:0] pc_target_r;
	reg [PC_W-1:0] pc_target_nxt;
	reg discard_r;
	reg discard_nxt;
	reg state_r;
	reg state_nxt;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_dc;
	wire alu_z;
	wire is_shift;
	wire use_carry;
	wire [PC_W-1:0] ofs_ext;

	// Machine states, kept as localparams so the case reads by name
	localparam ST_EXEC = `ABX_ST_EXEC;
	localparam ST_FLUSH = `ABX_ST_FLUSH;

	////////////////////////////////////////////////////////////////////////////////
	// Mask with only the selected bit set; bit clear and bit test share it
	function [7:0] bit_mask;
		input [2:0] idx;
		begin
			bit_mask = 8'h01 << idx;
		end
	endfunction

	// Target of the relative jump; wraps at the top of the program space
	function [PC_W-1:0] jump_dest;
		input [PC_W-1:0] pc;
		input [PC_W-1:0] ofs;
		begin
			jump_dest = pc + {{(PC_W-1){1'b0}}, 1'b1} + ofs;
		end
	endfunction

	assign is_shift = (op == `ABX_OP_ASR);
	assign use_carry = (op == `ABX_OP_ADDC) & flags_r[`ABX_BIT_C];
	// Sign extension lets one adder cover both jump directions
	assign ofs_ext = {{(PC_W-`ABX_OFS_W){jump_ofs[`ABX_OFS_W-1]}}, jump_ofs};

	abx_alu u_alu (
		.a(acc_r),
		.b(file_rdata),
		.cin(use_carry),
		.shift(is_shift),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.z_out(alu_z)
	);

	////////////////////////////////////////////////////////////////////////////////
	always @* begin
		acc_nxt = acc_r;
		flags_nxt = flags_r;
		file_we_nxt = 1'b0;
		file_wdata_nxt = file_wdata_r;
		pc_load_nxt = 1'b0;
		pc_target_nxt = pc_target_r;
		discard_nxt = 1'b0;
		state_nxt = ST_EXEC;
		case (state_r)
		ST_FLUSH: begin
			// Second cycle runs as a no-operation; requests are ignored here
			state_nxt = ST_EXEC;
		end
		default: begin
			if (instr_valid) begin
				case (op)
				`ABX_OP_ADD, `ABX_OP_ADDC, `ABX_OP_ASR: begin
					if (dest_sel == `ABX_DEST_FILE) begin
						file_we_nxt = 1'b1;
						file_wdata_nxt = alu_res;
					end else begin
						acc_nxt = alu_res;
					end
					flags_nxt[`ABX_BIT_C] = alu_c;
					flags_nxt[`ABX_BIT_Z] = alu_z;
					if (!is_shift) begin
						flags_nxt[`ABX_BIT_DC] = alu_dc;
					end
				end
				`ABX_OP_BCLR: begin
					file_we_nxt = 1'b1;
					file_wdata_nxt = file_rdata & ~bit_mask(bit_sel);
				end
				`ABX_OP_BTSZ: begin
					if ((file_rdata & bit_mask(bit_sel)) == 8'h00) begin
						discard_nxt = 1'b1;
						state_nxt = ST_FLUSH;
					end
				end
				`ABX_OP_BRA: begin
					pc_load_nxt = 1'b1;
					pc_target_nxt = jump_dest(pc_in, ofs_ext);
					state_nxt = ST_FLUSH;
				end
				default: begin
					state_nxt = ST_EXEC;
				end
				endcase
			end
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= `ABX_ACC_RST;
			flags_r <= `ABX_FLAGS_RST;
			file_we_r <= 1'b0;
			file_waddr_r <= {ADDR_W{1'b0}};
			file_wdata_r <= 8'h00;
			pc_load_r <= 1'b0;
			pc_target_r <= `ABX_PC_RST;
			discard_r <= 1'b0;
			state_r <= ST_EXEC;
		end else begin
			acc_r <= acc_nxt;
			flags_r <= flags_nxt;
			file_we_r <= file_we_nxt;
			// Address is captured only for an accepted request, so it stands with the write pulse
			if (instr_valid && state_r == ST_EXEC) begin
				file_waddr_r <= file_addr;
			end
			file_wdata_r <= file_wdata_nxt;
			pc_load_r <= pc_load_nxt;
			pc_target_r <= pc_target_nxt;
			discard_r <= discard_nxt;
			state_r <= state_nxt;
		end
	end

	assign acc = acc_r;
	assign carry_flag = flags_r[`ABX_BIT_C];
	assign half_carry_flag = flags_r[`ABX_BIT_DC];
	assign zero_flag = flags_r[`ABX_BIT_Z];
	assign file_we = file_we_r;
	assign file_waddr = file_waddr_r;
	assign file_wdata = file_wdata_r;
	assign pc_load = pc_load_r;
	assign pc_target = pc_target_r;
	assign discard_next = discard_r;
	// Busy marks the no-operation cycle so fetch holds off
	assign busy = state_r;
endmodule // abx_exec

/* File: testbench/abx_monitor.sv */
// Checker: result and timing relations at the execution block ports
`timescale 1ns/10ps
module abx_monitor #(parameter ADDR_W=7, parameter PC_W=15) (
input wire clk, rst_n, instr_valid, dest_sel, carry_flag, half_carry_flag, zero_flag,
input wire file_we, pc_load, discard_next, busy,
input wire [2:0] op, bit_sel,
input wire [ADDR_W-1:0] file_addr, file_waddr,
input wire [8:0] jump_ofs,
input wire [PC_W-1:0] pc_in, pc_target,
input wire [7:0] file_rdata, acc, file_wdata);
reg t_r, d_r, c_r;
reg [2:0] o_r, b_r;
reg [7:0] f_r, a_r;
reg [ADDR_W-1:0] ad_r;
reg [PC_W-1:0] p_r;
wire signed [PC_W-1:0] ofs = $signed(jump_ofs);
// Operands seen at the taking edge, so each property but p_two reads one cycle back
always @(posedge clk) begin
	t_r <= instr_valid && !busy;
	{o_r, d_r, b_r, f_r, a_r, c_r, ad_r} <= {op, dest_sel, bit_sel, file_rdata, acc, carry_flag, file_addr};
	p_r <= pc_in + 1 + ofs;
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
property p_jmp; t_r && o_r == 5 |-> pc_load && busy && pc_target == p_r; endproperty
a_jmp: assert property (p_jmp) else $error("jump target");
property p_two; pc_load |=> !busy && !pc_load; endproperty
a_two: assert property (p_two) else $error("jump length");
property p_skp; t_r && o_r == 4 |-> discard_next == !f_r[b_r] && busy == !f_r[b_r]; endproperty
a_skp: assert property (p_skp) else $error("skip");
property p_fl; t_r && o_r >= 3 |-> $stable({carry_flag, half_carry_flag, zero_flag}); endproperty
a_fl: assert property (p_fl) else $error("flags moved");
property p_bcl; t_r && o_r == 3 |-> file_we && file_waddr == ad_r && file_wdata == (f_r & ~(8'h01 << b_r)); endproperty
a_bcl: assert property (p_bcl) else $error("bit clear");
property p_add; t_r && o_r < 2 && !d_r |-> {carry_flag, acc} == a_r + f_r + (o_r[0] & c_r) && zero_flag == (acc == 0);
endproperty
a_add: assert property (p_add) else $error("add");
property p_hc; t_r && o_r < 2 |-> half_carry_flag == (a_r[3:0] + f_r[3:0] + (o_r[0] & c_r) > 5'h0f); endproperty
a_hc: assert property (p_hc) else $error("half carry");
property p_asr; t_r && o_r == 2 && !d_r |-> acc == {f_r[7], f_r[7:1]} && carry_flag == f_r[0]; endproperty
a_asr: assert property (p_asr) else $error("shift");
endmodule // abx_monitor
bind abx_exec abx_monitor #(.ADDR_W(ADDR_W), .PC_W(PC_W)) abx_monitor_i (.*);

/* File: testbench/abx_file_model.sv */
// Data register file seen by the execution block
`timescale 1ns/10ps
module abx_file_model (
input wire clk, file_we,
input wire [6:0] file_addr, file_waddr,
input wire [7:0] file_wdata,
output wire [7:0] file_rdata);
reg [7:0] mem_r [0:127];
integer k;
initial for (k = 0; k < 128; k = k + 1) mem_r[k] = k * 8'h5b;
assign file_rdata = mem_r[file_addr];
always @(posedge clk) if (file_we) mem_r[file_waddr] <= file_wdata;
endmodule // abx_file_model

/* File: testbench/abx_exec_bench.sv */
// Bench: random instruction stream checked against a reference model
`timescale 1ns/10ps
module abx_exec_bench;
reg clk = 0, rst_n = 0, instr_valid = 0, dest_sel = 0;
reg [2:0] op = 0, bit_sel = 0;
reg [6:0] file_addr = 0;
reg [8:0] jump_ofs = 0, s;
reg [14:0] pc_in = 0, pt = 0;
wire [7:0] acc, file_rdata, file_wdata;
wire [6:0] file_waddr;
wire [14:0] pc_target;
wire carry_flag, half_carry_flag, zero_flag, file_we, pc_load, discard_next, busy;
reg [37:0] q [$];
reg [31:0] x = 56916;
reg [7:0] f, r, a = 0, wd;
reg c = 0, h = 0, z = 0, we, pl, dn, bz = 0;
integer fails = 0, n_compared = 0, i;
abx_exec abx_exec_i (.*);
abx_file_model abx_file_model_i (.*);
initial forever #50 clk = ~clk;
function [31:0] xs(input [31:0] v);
	xs = v ^ (v << 13);
	xs = xs ^ (xs >> 17);
	xs = xs ^ (xs << 5);
endfunction
task chk(input [37:0] ex, input [37:0] got);
	n_compared = n_compared + 1;
	if (got !== ex) begin
		fails = fails + 1;
		$display("BAD outputs exp %h got %h", ex, got);
	end
endtask
task test_done;
	$display("compared %0d failed %0d", n_compared, fails);
	if (fails == 0 && n_compared > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
always @(posedge clk) if (q.size() > 0) begin
	#1 chk(q.pop_front(), {acc, carry_flag, half_carry_flag, zero_flag, file_we, file_we ? file_wdata : 8'h00,
		pc_load, pc_target, discard_next, busy});
end
initial begin
	repeat (2) @(posedge clk);
	@(negedge clk) rst_n = 1;
	for (i = 0; i < 3000; i = i + 1) begin
		@(negedge clk);
		x = xs(x);
		{pc_in, instr_valid, jump_ofs, bit_sel, dest_sel, file_addr, op} = {x[31:17], x[23] | x[24], x[22:0]};
		f = abx_file_model_i.mem_r[file_addr];
		{we, pl, dn, wd} = 0;
		// Requests during the busy cycle must leave every port alone
		if (instr_valid && !bz) case (op)
			0, 1, 2: begin
				if (op == 2) {r, c} = {f[7], f};
				else begin
					s = a + f + (op[0] & c);
					h = a[3:0] + f[3:0] + (op[0] & c) > 5'h0f;
					{c, r} = s;
				end
				z = r == 0;
				if (dest_sel) {we, wd} = {1'b1, r};
				else a = r;
			end
			3: {we, wd} = {1'b1, f & ~(8'h01 << bit_sel)};
			4: dn = !f[bit_sel];
			5: {pl, pt} = {1'b1, pc_in + 15'h0001 + {{6{jump_ofs[8]}}, jump_ofs}};
		endcase
		bz = dn | pl;
		q.push_back({a, c, h, z, we, wd, pl, pt, dn, bz});
	end
	@(negedge clk);
	$display("test random_stream done");
	test_done;
end
endmodule // abx_exec_bench
